// ---- src/dspc_sector_counter.sv ----
/*
 * Sector pulse generator with current sector counter and APB registers.
 * Assumes all pins arrive asynchronously to mclk and that the selected
 * counter clock and the servo clock run well below mclk / 6.
 */
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`include "dspc_cfg.svh"

module dspc_sector_counter
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive pins
    input wire dspc_pkg::dspc_pins_t pins,
    output logic sectorPulse,
    output logic [7:0] busIn,
    output logic busInValid
);
    import dspc_pkg::*;

    localparam int PW = `DSPC_PULSE_CYC;
    // Last cycle index of the pulse, counted from its first high cycle
    localparam int PW_LAST = PW - 1;

    // ======================================================================
    // Registers
    dspc_pins_t sync1_reg, sync2_reg, sync3_reg, stable_reg;
    logic [2:0] byteDiv_reg;
    dspc_cfg_t cfg_reg;
    logic [15:0] ppr_reg;
    logic [7:0] sectors_reg;
    logic [15:0] preset_reg;
    logic [15:0] cnt_reg;
    logic [15:0] pos_reg;
    logic [7:0] curSect_reg;
    logic [7:0] pulseCnt_reg;
    logic runtSeen_reg;
    logic sectorPulse_reg;
    logic [7:0] busIn_reg;
    logic busInValid_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    // ======================================================================
    // Pin synchronisers: a change counts once stages two and three agree
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            stable_reg <= '0;
        end
        else
        begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int i = 0; i < 4; i++)
            begin
                if (sync2_reg[i] == sync3_reg[i])
                begin
                    stable_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    // Rising edges of the filtered pins
    logic sectRise, servoRise, tagRise;
    logic indexLvl;
    assign sectRise = (sync2_reg.sectorClk == sync3_reg.sectorClk) && sync3_reg.sectorClk && !stable_reg.sectorClk;
    assign servoRise = (sync2_reg.servoClk == sync3_reg.servoClk) && sync3_reg.servoClk && !stable_reg.servoClk;
    assign tagRise = (sync2_reg.tag4 == sync3_reg.tag4) && sync3_reg.tag4 && !stable_reg.tag4;
    assign indexLvl = stable_reg.index;

    // ======================================================================
    // Byte clock: servo clock divided down to a one-cycle enable
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            byteDiv_reg <= '0;
        end
        else if (servoRise)
        begin
            byteDiv_reg <= byteDiv_reg + 3'h1;
        end
    end

    // Counter clock select
    logic tick;
    always_comb
    begin
        if (cfg_reg.clkSel == DSPC_CLK_BYTE)
        begin
            tick = servoRise && (byteDiv_reg == 3'(`DSPC_BYTE_DIV - 1));
        end
        else
        begin
            tick = sectRise;
        end
    end

    // ======================================================================
    // APB access decode; writes land at the access edge only
    logic setup, wrEn;
    assign setup = psel && !penable;
    assign wrEn = psel && penable && pready_reg && pwrite;

    // Switch settings written by software
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_reg <= '0;
            ppr_reg <= `DSPC_RST_PPR;
            sectors_reg <= `DSPC_RST_SECTORS;
        end
        else if (wrEn)
        begin
            if (paddr == `DSPC_OFS_CTRL)
            begin
                cfg_reg.clkSel <= dspc_clk_sel_t'(pwdata[`DSPC_CTRL_CLKSEL]);
                cfg_reg.runtSuppress <= pwdata[`DSPC_CTRL_RUNT];
            end
            else if (paddr == `DSPC_OFS_PPR)
            begin
                ppr_reg <= pwdata[15:0];
            end
            else if (paddr == `DSPC_OFS_SECTORS)
            begin
                sectors_reg <= pwdata[7:0];
            end
        end
    end

    // Preset follows the setting; a zero sector count leaves a preset of zero
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // Matches the reset switch settings, so the preset is never stale after reset
            preset_reg <= 16'(`DSPC_RST_PPR / `DSPC_RST_SECTORS - 1);
        end
        else if (sectors_reg == 8'h00 || ppr_reg < 16'(sectors_reg))
        begin
            preset_reg <= '0;
        end
        else
        begin
            preset_reg <= 16'(ppr_reg / 16'(sectors_reg)) - 16'h0001;
        end
    end

    // Read data and answer are set up in the setup cycle, so one wait-free access
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= setup;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
            if (setup)
            begin
                if (paddr == `DSPC_OFS_CTRL)
                begin
                    prdata_reg <= {30'h0, cfg_reg.runtSuppress, cfg_reg.clkSel};
                end
                else if (paddr == `DSPC_OFS_PPR)
                begin
                    prdata_reg <= {16'h0, ppr_reg};
                end
                else if (paddr == `DSPC_OFS_SECTORS)
                begin
                    prdata_reg <= {24'h0, sectors_reg};
                end
                else if (paddr == `DSPC_OFS_PRESET)
                begin
                    prdata_reg <= {16'h0, preset_reg};
                end
                else if (paddr == `DSPC_OFS_STATUS)
                begin
                    prdata_reg <= {22'h0, runtSeen_reg, indexLvl, curSect_reg};
                end
                else
                begin
                    pslverr_reg <= 1'b1;
                end
            end
        end
    end

    // ======================================================================
    // Down counter; zero is reached by decrement or by a zero preset
    logic [15:0] cntNext, posNext, remain;
    logic borrow, runt;
    assign cntNext = (cnt_reg == 16'h0000) ? preset_reg : cnt_reg - 16'h0001;
    assign posNext = (pos_reg == 16'hffff) ? pos_reg : pos_reg + 16'h0001;
    assign remain = (posNext >= ppr_reg) ? 16'h0000 : ppr_reg - posNext;
    assign borrow = tick && !indexLvl && (cntNext == 16'h0000);
    assign runt = cfg_reg.runtSuppress && (remain < preset_reg);

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_reg <= '0;
        end
        else if (indexLvl)
        begin
            cnt_reg <= preset_reg;
        end
        else if (tick)
        begin
            cnt_reg <= cntNext;
        end
    end

    // Clocks since index, the reference for judging a runt
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pos_reg <= '0;
        end
        else if (indexLvl)
        begin
            pos_reg <= '0;
        end
        else if (tick)
        begin
            pos_reg <= posNext;
        end
    end

    // ======================================================================
    // Sector pulse one-shot; a retrigger restarts the width
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pulseCnt_reg <= '0;
            sectorPulse_reg <= 1'b0;
        end
        else if (borrow && !runt)
        begin
            pulseCnt_reg <= 8'(PW - 1);
            sectorPulse_reg <= 1'b1;
        end
        else if (pulseCnt_reg != 8'h00)
        begin
            pulseCnt_reg <= pulseCnt_reg - 8'h01;
        end
        else
        begin
            sectorPulse_reg <= 1'b0;
        end
    end

    // Sticky note of a dropped runt, cleared by the next index
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            runtSeen_reg <= 1'b0;
        end
        else if (borrow && runt)
        begin
            runtSeen_reg <= 1'b1;
        end
        else if (indexLvl)
        begin
            runtSeen_reg <= 1'b0;
        end
    end

    // ======================================================================
    // Current sector counter, counts only pulses that are output
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            curSect_reg <= '0;
        end
        else if (indexLvl)
        begin
            curSect_reg <= '0;
        end
        else if (borrow && !runt)
        begin
            curSect_reg <= curSect_reg + 8'h01;
        end
    end

    // Tag 4 latches the address; it stands until the tag line drops
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busIn_reg <= '0;
            busInValid_reg <= 1'b0;
        end
        else if (tagRise)
        begin
            busIn_reg <= curSect_reg;
            busInValid_reg <= 1'b1;
        end
        else if (!stable_reg.tag4)
        begin
            busInValid_reg <= 1'b0;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign sectorPulse = sectorPulse_reg;
    assign busIn = busIn_reg;
    assign busInValid = busInValid_reg;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    property p_preset_bound;
        (sectors_reg != 8'h00 && ppr_reg >= 16'(sectors_reg) && $stable(ppr_reg) && $stable(sectors_reg))
            |-> (32'(preset_reg) + 32'd1) * 32'(sectors_reg) <= 32'(ppr_reg)
                && (32'(preset_reg) + 32'd2) * 32'(sectors_reg) > 32'(ppr_reg);
    endproperty
    a_preset_bound: assert property (p_preset_bound) else $error("preset not floor(ppr/sectors)-1");

    property p_decrement;
        tick && !indexLvl && cnt_reg != 16'h0000 |=> cnt_reg == $past(cnt_reg) - 16'h0001;
    endproperty
    a_decrement: assert property (p_decrement) else $error("counter did not decrement");

    property p_reload;
        tick && !indexLvl && cnt_reg == 16'h0000 |=> cnt_reg == $past(preset_reg);
    endproperty
    a_reload: assert property (p_reload) else $error("counter did not reload after zero");

    property p_index_hold;
        indexLvl ##1 indexLvl |-> cnt_reg == $past(preset_reg) && curSect_reg == 8'h00;
    endproperty
    a_index_hold: assert property (p_index_hold) else $error("counter moved during index");

    property p_pulse_width;
        $rose(sectorPulse_reg) |-> sectorPulse_reg throughout ##[PW_LAST:PW_LAST] 1'b1;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("sector pulse too short");

    property p_runt_drop;
        borrow && runt |=> curSect_reg == $past(curSect_reg) && runtSeen_reg;
    endproperty
    a_runt_drop: assert property (p_runt_drop) else $error("runt borrow was counted");

    property p_no_suppress;
        borrow && !cfg_reg.runtSuppress |=> sectorPulse_reg && curSect_reg == $past(curSect_reg) + 8'h01;
    endproperty
    a_no_suppress: assert property (p_no_suppress) else $error("borrow without pulse");

    property p_index_clear;
        indexLvl |=> curSect_reg == 8'h00;
    endproperty
    a_index_clear: assert property (p_index_clear) else $error("sector count not cleared by index");

    property p_tag_read;
        tagRise |=> busInValid_reg && busIn_reg == $past(curSect_reg);
    endproperty
    a_tag_read: assert property (p_tag_read) else $error("tag 4 did not present sector");

    c_pulse: cover property (borrow && !runt);
    c_runt: cover property (borrow && runt);
    c_byte_tick: cover property (tick && cfg_reg.clkSel == DSPC_CLK_BYTE);
    c_tag: cover property (tagRise ##1 busInValid_reg);

endmodule // dspc_sector_counter

// ---- src/dspc_cfg.svh ----
/*
 * Constants for the disc sector pulse counter: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 125 MHz mclk and a 32-bit APB register bus.
 */
`ifndef DSPC_CFG_SVH
`define DSPC_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define DSPC_OFS_CTRL 12'h000
`define DSPC_OFS_PPR 12'h004
`define DSPC_OFS_SECTORS 12'h008
`define DSPC_OFS_PRESET 12'h00c
`define DSPC_OFS_STATUS 12'h010

// ==========================================================================
// Field positions
`define DSPC_CTRL_CLKSEL 0
`define DSPC_CTRL_RUNT 1
`define DSPC_STAT_INDEX 8
`define DSPC_STAT_RUNT 9

// ==========================================================================
// Reset values
`define DSPC_RST_PPR 16'h6900
`define DSPC_RST_SECTORS 8'h40

// ==========================================================================
// Timing: sector pulse width in ns, and its length in mclk cycles
`define DSPC_CLK_MHZ 125
`define DSPC_PULSE_NS 200
`define DSPC_PULSE_CYC ((`DSPC_PULSE_NS * `DSPC_CLK_MHZ + 999) / 1000)
`define DSPC_BYTE_DIV 8

`endif

// ---- src/dspc_pkg.sv ----
/*
 * Types shared by the disc sector pulse counter.
 * Assumes dspc_cfg.svh holds all numeric constants.
 */
package dspc_pkg;

    // ======================================================================
    // Counter clock choice
    typedef enum logic {DSPC_CLK_SECTOR, DSPC_CLK_BYTE} dspc_clk_sel_t;

    // ======================================================================
    // Pins arriving from outside the mclk domain
    typedef struct packed {
        logic tag4;
        logic servoClk;
        logic sectorClk;
        logic index;
    } dspc_pins_t;

    // ======================================================================
    // Switch settings held in the control register
    typedef struct packed {
        logic runtSuppress;
        dspc_clk_sel_t clkSel;
    } dspc_cfg_t;

endpackage

// ---- verification/dspc_ctl_model.sv ----
/*
 * Storage controller and drive pin model facing the sector pulse counter.
 * Assumes the bench calls one task at a time, each entered just after a
 * rising edge of mclk.
 */
`timescale 1ns/100ps

module dspc_ctl_model
(
    // Clock
    input wire logic mclk,
    // Pins toward the counter and sector address back
    output dspc_pkg::dspc_pins_t pins,
    input wire logic [7:0] busIn,
    input wire logic busInValid
);
    import dspc_pkg::*;

    // ==========================================================================
    // Idle pins
    initial pins = '0;

    // One counter clock; spacing stays above the pulse width so pulses never merge
    task automatic tick(input bit byteMode);
        if (byteMode)
        begin
            repeat (8)
            begin
                pins.servoClk <= 1'b1;
                repeat (4) @(posedge mclk);
                pins.servoClk <= 1'b0;
                repeat (4) @(posedge mclk);
            end
        end
        else
        begin
            pins.sectorClk <= 1'b1;
            repeat (16) @(posedge mclk);
            pins.sectorClk <= 1'b0;
            repeat (16) @(posedge mclk);
        end
    endtask

    // Index with a counter clock inside it, which must be ignored
    task automatic index_pulse(input bit byteMode);
        pins.index <= 1'b1;
        repeat (6) @(posedge mclk);
        tick(byteMode);
        pins.index <= 1'b0;
        repeat (40) @(posedge mclk);
    endtask

    // Sector address read; ok falls if either wait runs out
    task automatic tag_read(output logic [7:0] val, output bit ok);
        int n;
        ok = 1'b0;
        pins.tag4 <= 1'b1;
        for (n = 0; n < 20 && !ok; n++)
        begin
            @(posedge mclk);
            ok = (busInValid === 1'b1);
        end
        val = busIn;
        pins.tag4 <= 1'b0;
        for (n = 0; n < 20 && busInValid !== 1'b0; n++)
            @(posedge mclk);
        ok = ok && (n < 20);
    endtask
endmodule // dspc_ctl_model

// ---- verification/test_disc_sector_pulse_counter.sv ----
/*
 * Self-checking bench for the sector pulse counter: APB register checks and
 * whole rotations in both clock modes, with and without runt suppression.
 * Assumes dspc_ctl_model drives the pins and the APB slave never waits.
 */
`timescale 1ns/100ps
`include "dspc_cfg.svh"

module test_disc_sector_pulse_counter;
    import dspc_pkg::*;

    // ==========================================================================
    // Signals
    logic mclk;
    logic arst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    dspc_pins_t pins;
    logic sectorPulse;
    logic [7:0] busIn;
    logic busInValid;
    logic pulseLast = 1'b0;
    int pulseCount = 0;
    int bad_count = 0;
    int checks = 0;
    int seed = 37;

    dspc_sector_counter dut_u (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .sectorPulse(sectorPulse), .busIn(busIn), .busInValid(busInValid));

    dspc_ctl_model ctl_u (.mclk(mclk), .pins(pins), .busIn(busIn), .busInValid(busInValid));

    // ==========================================================================
    // Clock and pulse counting on rising edges of the output
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        pulseLast <= sectorPulse;
        if (sectorPulse === 1'b1 && pulseLast !== 1'b1)
            pulseCount <= pulseCount + 1;
    end

    // ==========================================================================
    // Reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic results();
        $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic timeout();
        bad_count++;
        $display("unexpected at %0t: wait ran out", $time);
        results();
    endtask

    // ==========================================================================
    // APB master; an idle edge first so psel is never set twice in one step
    task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] v, output logic [31:0] d,
        output logic e);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge mclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
            timeout();
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, v, d, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] want);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, '0, d, e);
        check(d, want);
    endtask

    // ==========================================================================
    // One rotation against a model of borrows, runt drops and sector count
    task automatic rotation(input int i);
        int ppr;
        int sects;
        int pre;
        int cnt;
        int t;
        bit runt;
        bit byteMode;
        bit supp;
        bit ok;
        logic [7:0] tagVal;
        byteMode = i[0];
        supp = i[1];
        ppr = (i == 4) ? 5 : (supp ? 29 : 20 + $unsigned($random(seed)) % 16);
        sects = (i == 4) ? 9 : (supp ? 4 : 3 + $unsigned($random(seed)) % 4);
        pre = (sects > ppr) ? 0 : ppr / sects - 1;
        cnt = 0;
        runt = 1'b0;
        for (t = 1; t <= ppr; t++)
            if (t >= pre && (t - pre) % (pre + 1) == 0)
            begin
                if (supp && ppr - t < pre)
                    runt = 1'b1;
                else
                    cnt++;
            end
        wr(`DSPC_OFS_CTRL, {30'h0, supp, byteMode});
        wr(`DSPC_OFS_PPR, ppr);
        wr(`DSPC_OFS_SECTORS, sects);
        rd(`DSPC_OFS_PRESET, pre);
        ctl_u.index_pulse(byteMode);
        pulseCount = 0;
        repeat (ppr) ctl_u.tick(byteMode);
        repeat (40) @(posedge mclk);
        check(pulseCount, cnt);
        rd(`DSPC_OFS_STATUS, {runt, 1'b0, cnt[7:0]});
        ctl_u.tag_read(tagVal, ok);
        if (!ok)
            timeout();
        check(tagVal, cnt);
        ctl_u.index_pulse(byteMode);
        rd(`DSPC_OFS_STATUS, 32'h0);
        $display("test rotation %0d done", i);
    endtask

    // ==========================================================================
    // Main sequence
    initial
    begin
        logic [31:0] d;
        logic e;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        rd(`DSPC_OFS_CTRL, 32'h0);
        rd(`DSPC_OFS_PPR, `DSPC_RST_PPR);
        rd(`DSPC_OFS_SECTORS, `DSPC_RST_SECTORS);
        rd(`DSPC_OFS_PRESET, `DSPC_RST_PPR / `DSPC_RST_SECTORS - 1);
        wr(`DSPC_OFS_PRESET, 32'h5);
        rd(`DSPC_OFS_PRESET, `DSPC_RST_PPR / `DSPC_RST_SECTORS - 1);
        apb(1'b0, 12'h014, '0, d, e);
        check(e, 1'b1);
        check(d, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 5; i++)
            rotation(i);
        results();
    end
endmodule // test_disc_sector_pulse_counter
